// file: design/ecram_pkg.sv
// Shared constants and types for the dual-clock embedded memory block
package ecram_pkg;
	localparam int ADDR_W = 11;
	localparam int DATA_W = 16;
	localparam int MEM_BITS = 2048;
	localparam int SHAPE_W = 3;
	// Shape codes: word count doubles as the word width halves
	localparam logic [2:0] SHAPE_128X16 = 3'h0;
	localparam logic [2:0] SHAPE_256X8 = 3'h1;
	localparam logic [2:0] SHAPE_512X4 = 3'h2;
	localparam logic [2:0] SHAPE_1024X2 = 3'h3;
	localparam logic [2:0] SHAPE_2048X1 = 3'h4;
	// log2 of the widest word; bit base is the address shifted by this less
	// the shape code
	localparam logic [2:0] WIDE_LOG2 = 3'h4;
	localparam logic [15:0] DOUT_RST = 16'h0000;
	localparam logic WR_PEND_RST = 1'b0;
	typedef enum logic [1:0] {
		MODE_RW = 2'h1,
		MODE_IO = 2'h2
	} clk_mode_t;
endpackage

// file: design/side_reg.sv
// Port register with load enable and asynchronous clear
`timescale 1ns/1ps
module side_reg #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic load,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] q_d;

	always_comb begin
		q_d = load ? d : q;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			q <= '0;
		end else begin
			q <= q_d;
		end
	end
endmodule

// file: design/dual_clock_embedded_ram.sv
// Dual-port embedded memory block with two port rates
//
// How it works
// - Two arrangements: read/write port rates, or input/output port rates.
// - Write data, write strobe and write address load on the write rate only.
// - Data out loads on the read rate; read strobe and read address load on the read rate, or on the input rate in input/output mode.
// - Each side has its own enable and clear, touching only its registers.
// - Local clear, global clear or chip reset clears registers asynchronously.
// - Write and read rates are independent, with no assumed phase relation.
// - Array shapes: 128x16, 256x8, 512x4, 1024x2 or 2048x1.
// - Internal write pulse follows the registered strobe; writes are self-timed.
`timescale 1ns/1ps
module dual_clock_embedded_ram
	import ecram_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic glob_clr,
	input wire clk_mode_t clk_mode,
	input wire logic [SHAPE_W-1:0] shape,
	input wire logic tick_a,
	input wire logic ce_a,
	input wire logic clr_a,
	input wire logic tick_b,
	input wire logic ce_b,
	input wire logic clr_b,
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic write_strobe,
	input wire logic [ADDR_W-1:0] wr_addr,
	input wire logic read_strobe,
	input wire logic [ADDR_W-1:0] rd_addr,
	output logic [DATA_W-1:0] rd_data_q
);
	////////////////////////////////////////////////////////////////////////
	// Side enables and clears
	logic io_mode;
	logic arst_a_n;
	logic arst_b_n;
	logic load_a;
	logic load_b;
	logic rin_load;
	logic rin_arst_n;
	logic [2:0] shape_ok;

	// Any clear source resets a side at once, without waiting for a tick
	assign arst_a_n = rst_n & ~glob_clr & ~clr_a;
	assign arst_b_n = rst_n & ~glob_clr & ~clr_b;
	// The sides share no load term, so their rates may be unrelated
	assign load_a = tick_a & ce_a;
	assign load_b = tick_b & ce_b;
	// Read-side inputs follow the input rate in input/output mode
	assign io_mode = (clk_mode == MODE_IO);
	assign rin_load = io_mode ? load_a : load_b;
	assign rin_arst_n = io_mode ? arst_a_n : arst_b_n;
	// An unused shape code falls back to the widest word
	assign shape_ok = (shape > SHAPE_2048X1) ? SHAPE_128X16 : shape;

	////////////////////////////////////////////////////////////////////////
	// Port registers
	logic wr_strobe_q;
	logic [ADDR_W-1:0] wr_addr_q;
	logic [DATA_W-1:0] wr_data_q;
	logic rd_strobe_q;
	logic [ADDR_W-1:0] rd_addr_q;

	side_reg #(.W(1 + ADDR_W + DATA_W)) u_wr_in (
		.clk(clk),
		.arst_n(arst_a_n),
		.load(load_a),
		.d({write_strobe, wr_addr, wr_data}),
		.q({wr_strobe_q, wr_addr_q, wr_data_q})
	);

	side_reg #(.W(1 + ADDR_W)) u_rd_in (
		.clk(clk),
		.arst_n(rin_arst_n),
		.load(rin_load),
		.d({read_strobe, rd_addr}),
		.q({rd_strobe_q, rd_addr_q})
	);

	////////////////////////////////////////////////////////////////////////
	// Self-timed write pulse
	logic wr_pend_q;
	logic wr_pend_d;
	logic wr_pulse;

	// One pulse per write-side load with the strobe set, in the cycle the registers take the new values,
	// so the user only meets setup to the tick and never shapes a strobe
	always_comb begin
		wr_pend_d = load_a;
	end

	always_ff @(posedge clk or negedge arst_a_n) begin
		if (!arst_a_n) begin
			wr_pend_q <= WR_PEND_RST;
		end else begin
			wr_pend_q <= wr_pend_d;
		end
	end

	assign wr_pulse = wr_pend_q & wr_strobe_q;

	////////////////////////////////////////////////////////////////////////
	// Array, shaped by the shape code
	function automatic logic [ADDR_W-1:0] bit_base(
		input logic [ADDR_W-1:0] a,
		input logic [2:0] s
	);
		logic [2:0] sh;
		sh = 3'(WIDE_LOG2 - s);
		return ADDR_W'(a << sh);
	endfunction

	logic [MEM_BITS-1:0] mem_q;
	logic [MEM_BITS-1:0] mem_d;
	logic [ADDR_W-1:0] wbase;
	logic [ADDR_W-1:0] rbase;
	logic [DATA_W-1:0] rd_word;
	logic [4:0] lanes;

	assign wbase = bit_base(wr_addr_q, shape_ok);
	assign rbase = bit_base(rd_addr_q, shape_ok);
	assign lanes = 5'(5'h10 >> shape_ok);

	always_comb begin
		mem_d = mem_q;
		if (wr_pulse) begin
			for (int i = 0; i < DATA_W; i++) begin
				if (5'(i) < lanes) begin
					mem_d[ADDR_W'(wbase + ADDR_W'(i))] = wr_data_q[i];
				end
			end
		end
	end

	// Storage has no clear: only the port, output and pending-write registers are cleared
	always_ff @(posedge clk) begin
		mem_q <= mem_d;
	end

	always_comb begin
		rd_word = '0;
		for (int i = 0; i < DATA_W; i++) begin
			if (5'(i) < lanes) begin
				rd_word[i] = mem_q[ADDR_W'(rbase + ADDR_W'(i))];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output register
	logic [DATA_W-1:0] rd_data_d;

	// A same-address write in flight is not forwarded; the old stored word is read
	always_comb begin
		rd_data_d = rd_data_q;
		if (load_b && rd_strobe_q) begin
			rd_data_d = rd_word;
		end
	end

	always_ff @(posedge clk or negedge arst_b_n) begin
		if (!arst_b_n) begin
			rd_data_q <= DOUT_RST;
		end else begin
			rd_data_q <= rd_data_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	property p_wr_hold;
		@(posedge clk) disable iff (!arst_a_n)
		!load_a |=> $stable(wr_addr_q) && $stable(wr_data_q);
	endproperty
	a_wr_hold: assert property (p_wr_hold)
		else $error("write registers moved without a write tick");

	property p_rd_load;
		@(posedge clk) disable iff (!arst_b_n)
		load_b && rd_strobe_q |=> rd_data_q == $past(rd_word);
	endproperty
	a_rd_load: assert property (p_rd_load)
		else $error("read data not loaded on read tick");

	property p_side_a_clear;
		@(posedge clk) disable iff (!arst_b_n)
		clr_a && !load_b |=> $stable(rd_data_q);
	endproperty
	a_side_a_clear: assert property (p_side_a_clear)
		else $error("write clear disturbed read output");

	property p_side_b_clear;
		@(posedge clk) disable iff (!arst_a_n)
		clr_b && !load_a |=> $stable(wr_addr_q);
	endproperty
	a_side_b_clear: assert property (p_side_b_clear)
		else $error("read clear disturbed write registers");

	property p_glob_clear;
		@(posedge clk) disable iff (!rst_n)
		glob_clr |-> rd_data_q == '0 && wr_addr_q == '0 && !wr_pend_q
			&& rd_addr_q == '0;
	endproperty
	a_glob_clear: assert property (p_glob_clear)
		else $error("global clear left a register set");

	property p_pulse;
		@(posedge clk) disable iff (!arst_a_n)
		load_a ##1 1'b1 |-> wr_pulse == wr_strobe_q;
	endproperty
	a_pulse: assert property (p_pulse)
		else $error("write pulse does not follow registered strobe");

	property p_no_pulse;
		@(posedge clk) disable iff (!rst_n)
		!$past(load_a) |-> !wr_pulse;
	endproperty
	a_no_pulse: assert property (p_no_pulse)
		else $error("write pulse without a write tick");

	property p_store16;
		@(posedge clk) disable iff (!rst_n)
		wr_pulse && shape_ok == SHAPE_128X16 |=>
			mem_q[{$past(wr_addr_q[6:0]), 4'h0} +: 16] == $past(wr_data_q);
	endproperty
	a_store16: assert property (p_store16)
		else $error("wide word not stored");

	property p_io_route;
		@(posedge clk) disable iff (!arst_a_n || !arst_b_n)
		io_mode && load_a && !load_b && read_strobe |=> rd_strobe_q;
	endproperty
	a_io_route: assert property (p_io_route)
		else $error("input rate did not load read address in io mode");

	property p_cov_write;
		@(posedge clk) disable iff (!rst_n) wr_pulse;
	endproperty
	c_write: cover property (p_cov_write);

	property p_cov_read;
		@(posedge clk) disable iff (!rst_n) load_b && rd_strobe_q;
	endproperty
	c_read: cover property (p_cov_read);

	property p_cov_io;
		@(posedge clk) disable iff (!rst_n) io_mode && rin_load && read_strobe;
	endproperty
	c_io: cover property (p_cov_io);
endmodule

// file: tb/fabric_user.sv
// Fabric-side user logic that drives both memory ports
`timescale 1ns/1ps
module fabric_user
	import ecram_pkg::*;
(
	input wire logic clk,
	input wire logic io,
	input wire logic wr,
	input wire logic rd,
	input wire logic [ADDR_W-1:0] a,
	input wire logic [DATA_W-1:0] d,
	output logic tick_a,
	output logic write_strobe,
	output logic [ADDR_W-1:0] wr_addr,
	output logic [DATA_W-1:0] wr_data,
	output logic tick_b,
	output logic read_strobe,
	output logic [ADDR_W-1:0] rd_addr
);
	// One writer, one reader: two-way use would need a second block
	always @(posedge clk) begin
		// In the input/output arrangement a read also takes an input tick
		tick_a <= wr | (io & rd);
		write_strobe <= wr;
		// Idle buses show inverted values so stale data cannot pass
		wr_addr <= wr ? a : ~a;
		wr_data <= wr ? d : ~d;
		tick_b <= rd;
		read_strobe <= rd;
		rd_addr <= rd ? a : ~a;
	end
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the dual-clock embedded memory block
`timescale 1ns/1ps
module tb_top
	import ecram_pkg::*;
;
	logic clk = 0, rst_n = 0, glob_clr = 0, clr_a = 0, clr_b = 0;
	logic ce_a = 1, ce_b = 1, wr = 0, rd = 0;
	logic [2:0] shape = 3'h0;
	logic [10:0] a = 11'h0;
	logic [15:0] d = 16'h0, m;
	logic tick_a, tick_b, write_strobe, read_strobe;
	logic [10:0] wr_addr, rd_addr, ad[8];
	logic [15:0] wr_data, rd_data_q, dv[8];
	logic [31:0] seed = 32'hff880bd2;
	logic [15:0] expq[$];
	clk_mode_t clk_mode = MODE_RW;
	int bad_count = 0, checked = 0;
	event smp;
	initial forever #20 clk = ~clk;
	fabric_user u_fabric_user (.clk(clk), .wr(wr), .rd(rd), .a(a), .d(d),
		.io(clk_mode == MODE_IO),
		.tick_a(tick_a), .write_strobe(write_strobe), .wr_addr(wr_addr),
		.wr_data(wr_data), .tick_b(tick_b), .read_strobe(read_strobe),
		.rd_addr(rd_addr));
	dual_clock_embedded_ram u_dual_clock_embedded_ram (.clk(clk),
		.rst_n(rst_n), .glob_clr(glob_clr), .clk_mode(clk_mode),
		.shape(shape), .tick_a(tick_a), .ce_a(ce_a), .clr_a(clr_a),
		.tick_b(tick_b), .ce_b(ce_b), .clr_b(clr_b), .wr_data(wr_data),
		.write_strobe(write_strobe), .wr_addr(wr_addr),
		.read_strobe(read_strobe), .rd_addr(rd_addr),
		.rd_data_q(rd_data_q));
	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs(logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	task automatic chk(logic [15:0] seen, logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %0t read %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("checked %0d bad %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic cyc(logic w, logic r, logic [10:0] x, logic [15:0] y);
		@(posedge clk);
		wr <= w;
		rd <= r;
		a <= x;
		d <= y;
	endtask
	task automatic idle(int n);
		repeat (n) cyc(0, 0, a, d);
	endtask
	// Note the expectation once the output has had time to settle
	task automatic put(logic [15:0] x);
		idle(3);
		expq.push_back(x);
		-> smp;
	endtask
	// Two read ticks: address taken on the first, data out on the second
	task automatic rdx(logic [10:0] x, logic [15:0] y);
		cyc(0, 1, x, 16'h0);
		cyc(0, 1, x, 16'h0);
		put(y);
	endtask
	task automatic wrx(logic [10:0] x, logic [15:0] y);
		cyc(1, 0, x, y);
		idle(2);
	endtask
	task automatic pulse(logic [3:0] p);
		@(posedge clk);
		{clr_a, clr_b, glob_clr} <= p[2:0];
		rst_n <= ~p[3];
		@(posedge clk);
		{clr_a, clr_b, glob_clr} <= 3'h0;
		rst_n <= 1'b1;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial forever begin
		@(smp);
		#1;
		chk(rd_data_q, expq.pop_front());
	end
	initial begin
		repeat (3000) @(posedge clk);
		bad_count++;
		tally_and_finish;
	end
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		put(16'h0000);
		$display("test reset done");
		// Back-to-back writes, distinct within the 128-word depth
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			ad[i] = {4'h0, i[2:0], seed[3:0]};
			dv[i] = seed[31:16];
			cyc(1, 0, ad[i], dv[i]);
		end
		idle(2);
		foreach (ad[i]) rdx(ad[i], dv[i]);
		$display("test burst done");
		ce_a <= 1'b0;
		wrx(ad[0], ~dv[0]);
		idle(1);
		ce_a <= 1'b1;
		rdx(ad[0], dv[0]);
		ce_b <= 1'b0;
		rdx(ad[1], dv[0]);
		ce_b <= 1'b1;
		$display("test enables done");
		// Write-side clear must leave the read output alone
		pulse(4'h4);
		put(dv[0]);
		pulse(4'h2);
		put(16'h0000);
		rdx(ad[1], dv[1]);
		pulse(4'h1);
		put(16'h0000);
		rdx(ad[2], dv[2]);
		pulse(4'h8);
		put(16'h0000);
		rdx(ad[3], dv[3]);
		$display("test clears done");
		// Input/output arrangement: read address rides the input rate
		clk_mode <= MODE_IO;
		ce_b <= 1'b0;
		rdx(ad[5], dv[3]);
		ce_b <= 1'b1;
		ce_a <= 1'b0;
		// Address stays the one taken on the input rate, not the new one
		rdx(ad[6], dv[5]);
		ce_a <= 1'b1;
		rdx(ad[7], dv[7]);
		clk_mode <= MODE_RW;
		$display("test io mode done");
		for (int s = 0; s < 5; s++) begin
			shape <= s[2:0];
			seed = xs(seed);
			m = 16'hffff >> (16 - (16 >> s));
			wrx(seed[26:16], seed[15:0]);
			rdx(seed[26:16], seed[15:0] & m);
		end
		$display("test shapes done");
		idle(1);
		tally_and_finish;
	end
endmodule
